//--- hw/pwm_fault_pkg.sv
// shared constants for the pwm fault and adc trigger block
`default_nettype none
package pwm_fault_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_FAULT_LIMIT_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ADC_TRIGGER_COMPARE = 8'h04;
  localparam logic [7:0] OFS_BLANKING_CONTROL    = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS          = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK            = 8'h10;
  localparam logic [7:0] OFS_BLOCK_STATE         = 8'h14;

  // fault_limit_control fields
  localparam int FLC_MODE_LSB   = 0;
  localparam int FLC_POL_BIT    = 2;
  localparam int FLC_SRC_LSB    = 3;
  localparam int FLC_CLMODE_BIT = 7;
  localparam int FLC_CLPOL_BIT  = 8;
  localparam int FLC_CLSRC_LSB  = 9;
  localparam logic [15:0] FLC_IMPL_MASK = 16'h1fff;
  localparam logic [15:0] FLC_RESET     = 16'h0000;

  // adc_trigger_compare fields
  localparam int TRG_CMP_LSB = 3;
  localparam int TRG_CMP_W   = 13;
  localparam logic [15:0] TRG_IMPL_MASK = 16'hfff8;
  localparam logic [15:0] TRG_RESET     = 16'h0000;

  // blanking_control fields
  localparam int BLK_PERIOD_LSB = 3;
  localparam int BLK_PERIOD_W   = 7;
  localparam int BLK_CL_EN_BIT  = 10;
  localparam int BLK_FLT_EN_BIT = 11;
  localparam int BLK_LF_BIT     = 12;
  localparam int BLK_LR_BIT     = 13;
  localparam int BLK_HF_BIT     = 14;
  localparam int BLK_HR_BIT     = 15;
  localparam logic [15:0] BLK_IMPL_MASK = 16'hfff8;
  localparam logic [15:0] BLK_RESET     = 16'h0000;

  // interrupt status bits
  localparam int IRQ_FAULT_BIT   = 0;
  localparam int IRQ_TRIGGER_BIT = 1;
  localparam int IRQ_CLIMIT_BIT  = 2;
  localparam int IRQ_W           = 3;

  // fault source select codes
  localparam logic [3:0] SRC_CMP_FIRST    = 4'h0;
  localparam logic [3:0] SRC_CMP_LAST     = 4'h3;
  localparam logic [3:0] SRC_SHARED_FIRST = 4'h8;
  localparam logic [3:0] SRC_SHARED_LAST  = 4'hb;
  localparam logic [3:0] SRC_INDEP_TWO    = 4'hd;
  localparam logic [3:0] SRC_INDEP_FOUR   = 4'hf;

  // fault modes
  localparam logic [1:0] MODE_LATCHED  = 2'h0;
  localparam logic [1:0] MODE_CYCLE    = 2'h1;
  localparam logic [1:0] MODE_DISABLED = 2'h3;
endpackage : pwm_fault_pkg
`default_nettype wire

//--- hw/lead_edge_blanker.sv
// leading-edge blanking timer that masks an active-high input after an edge
`default_nettype none
module lead_edge_blanker #(
  parameter int CW = 7
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_nrst,
  // control
  input  wire logic          i_enable,
  input  wire logic [CW-1:0] i_period,
  input  wire logic          i_edge,
  // signal path
  input  wire logic          i_active,
  output logic               o_active
);
  initial begin
    if (CW < 1 || CW > 16) $error("lead_edge_blanker: CW out of range");
  end

  logic [CW-1:0] count_reg;

  // reload on every chosen edge so back-to-back edges extend the window
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_reg <= '0;
    end else if (i_enable && i_edge) begin
      count_reg <= i_period;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // masking only while enabled, otherwise the input passes straight
  always_comb begin
    o_active = i_active & ~(i_enable && count_reg != '0);
  end
endmodule : lead_edge_blanker
`default_nettype wire

//--- hw/pwm_fault_and_adc_trigger.sv
// fault forcing, current-limit blanking and adc trigger compare for one pwm generator
//
// Summary of operation
// - source codes 0 to 3 pick analog comparators one to four as fault.
// - codes 8 to 11 pick shared fault inputs one to four in order.
// - code 13 picks independent fault two, code 15 independent fault four.
// - polarity bit one means selected fault active low, zero active high.
// - mode 00 forces both outputs to fault values and latches the condition.
// - mode 01 forces both outputs to fault values cycle by cycle.
// - mode 11 disables the fault input; mode 10 is reserved.
// - the three low trigger compare bits always read as zero.
// - a trigger compare value of zero never produces a trigger.
// - implemented control and compare bits are read/write, zero after reset.
// - blanking enable applies leading-edge blanking to the current-limit input.
//
// Added by the designer: the placing of the registers and register access over APB.
`default_nettype none
module pwm_fault_and_adc_trigger
  import pwm_fault_pkg::*;
#(
  parameter int TB_W = 16
) (
  // clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_nrst,
  // apb slave
  input  wire logic            i_psel,
  input  wire logic            i_penable,
  input  wire logic            i_pwrite,
  input  wire logic [7:0]      i_paddr,
  input  wire logic [31:0]     i_pwdata,
  output logic [31:0]          o_prdata,
  output logic                 o_pready,
  output logic                 o_pslverr,
  // asynchronous fault pins and comparators
  input  wire logic [3:0]      i_comparator,
  input  wire logic [3:0]      i_shared_fault,
  input  wire logic            i_independent_fault_two,
  input  wire logic            i_independent_fault_four,
  // generator side, same clock
  input  wire logic [TB_W-1:0] i_time_base,
  input  wire logic            i_period_start,
  input  wire logic            i_pwm_high,
  input  wire logic            i_pwm_low,
  input  wire logic [1:0]      i_fault_output_values,
  // outputs
  output logic                 o_high_side_output,
  output logic                 o_low_side_output,
  output logic                 o_current_limit,
  output logic                 o_adc_trigger,
  output logic                 o_irq
);
  initial begin
    if (TB_W != 16) $error("pwm_fault_and_adc_trigger: TB_W must be 16");
  end

  // maps a source code onto the synchronised inputs; reserved codes read low
  function automatic logic pick_source(input logic [3:0] code, input logic [9:0] src);
    logic hit;
    hit = 1'b0;
    if (code <= SRC_CMP_LAST) begin
      hit = src[code[1:0]];
    end else if (code >= SRC_SHARED_FIRST && code <= SRC_SHARED_LAST) begin
      hit = src[4 + {2'b00, code[1:0]}];
    end else if (code == SRC_INDEP_TWO) begin
      hit = src[8];
    end else if (code == SRC_INDEP_FOUR) begin
      hit = src[9];
    end
    return hit;
  endfunction : pick_source

  // register file
  logic [15:0]      flc_reg;
  logic [15:0]      trg_reg;
  logic [15:0]      blk_reg;
  logic [IRQ_W-1:0] status_reg;
  logic [IRQ_W-1:0] mask_reg;

  // apb bookkeeping
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        access;
  logic        wr;
  logic        mapped;
  logic [31:0] rd_mux;

  // fault path
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic       fault_raw;
  logic       fault_act;
  logic       fault_blanked;
  logic       cl_raw;
  logic       cl_act;
  logic       cl_blanked;
  logic       latch_reg;
  logic       cycle_reg;
  logic       forcing;
  logic       fault_prev_reg;
  logic       cl_prev_reg;

  // blank triggers
  logic pwm_high_prev_reg;
  logic pwm_low_prev_reg;
  logic blank_edge;

  // trigger compare
  logic [15:0] cmp_full;
  logic        cmp_hit;
  logic        cmp_hit_prev_reg;
  logic        trig_event;

  // output flops
  logic high_reg;
  logic low_reg;
  logic cl_out_reg;
  logic trig_reg;
  logic irq_reg;

  // one wait state: pready rises in the second access cycle
  assign access = i_psel & i_penable & pready_reg;
  assign wr     = access & i_pwrite;
  assign mapped = (i_paddr[1:0] == 2'b00) && (i_paddr <= OFS_BLOCK_STATE);

  // read mux, unimplemented bits forced to zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      OFS_FAULT_LIMIT_CONTROL: rd_mux[15:0] = flc_reg & FLC_IMPL_MASK;
      OFS_ADC_TRIGGER_COMPARE: rd_mux[15:0] = trg_reg & TRG_IMPL_MASK;
      OFS_BLANKING_CONTROL:    rd_mux[15:0] = blk_reg & BLK_IMPL_MASK;
      OFS_INT_STATUS:          rd_mux[IRQ_W-1:0] = status_reg;
      OFS_INT_MASK:            rd_mux[IRQ_W-1:0] = mask_reg;
      OFS_BLOCK_STATE:         rd_mux[3:0] = {fault_act, cl_act, cycle_reg, latch_reg};
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  // apb handshake and read data
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= i_psel & i_penable & ~pready_reg;
      pslverr_reg <= i_psel & i_penable & ~pready_reg & ~mapped;
      if (i_psel && i_penable && !pready_reg) begin
        prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // control registers, cleared at reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flc_reg  <= FLC_RESET;
      trg_reg  <= TRG_RESET;
      blk_reg  <= BLK_RESET;
      mask_reg <= '0;
    end else if (wr) begin
      case (i_paddr)
        OFS_FAULT_LIMIT_CONTROL: flc_reg <= i_pwdata[15:0] & FLC_IMPL_MASK;
        OFS_ADC_TRIGGER_COMPARE: trg_reg <= i_pwdata[15:0] & TRG_IMPL_MASK;
        OFS_BLANKING_CONTROL:    blk_reg <= i_pwdata[15:0] & BLK_IMPL_MASK;
        OFS_INT_MASK:            mask_reg <= i_pwdata[IRQ_W-1:0];
        default:                 mask_reg <= mask_reg;
      endcase
    end
  end

  // two-flop synchroniser for every pin-side input
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {i_independent_fault_four, i_independent_fault_two,
                    i_shared_fault, i_comparator};
      sync2_reg <= sync1_reg;
    end
  end

  // source selection and polarity
  always_comb begin
    fault_raw = pick_source(flc_reg[FLC_SRC_LSB +: 4], sync2_reg);
    fault_act = fault_raw ^ flc_reg[FLC_POL_BIT];
    cl_raw    = pick_source(flc_reg[FLC_CLSRC_LSB +: 4], sync2_reg);
    cl_act    = (cl_raw ^ flc_reg[FLC_CLPOL_BIT]) & flc_reg[FLC_CLMODE_BIT];
  end

  // edges of the generator outputs that start a blanking window
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pwm_high_prev_reg <= 1'b0;
      pwm_low_prev_reg  <= 1'b0;
    end else begin
      pwm_high_prev_reg <= i_pwm_high;
      pwm_low_prev_reg  <= i_pwm_low;
    end
  end

  assign blank_edge = (blk_reg[BLK_HR_BIT] & i_pwm_high & ~pwm_high_prev_reg)
                    | (blk_reg[BLK_HF_BIT] & ~i_pwm_high & pwm_high_prev_reg)
                    | (blk_reg[BLK_LR_BIT] & i_pwm_low & ~pwm_low_prev_reg)
                    | (blk_reg[BLK_LF_BIT] & ~i_pwm_low & pwm_low_prev_reg);

  // current-limit input blanked only when its enable is set
  lead_edge_blanker #(
    .CW(BLK_PERIOD_W)
  ) u_cl_blank (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_enable(blk_reg[BLK_CL_EN_BIT]),
    .i_period(blk_reg[BLK_PERIOD_LSB +: BLK_PERIOD_W]),
    .i_edge  (blank_edge),
    .i_active(cl_act),
    .o_active(cl_blanked)
  );

  // fault input has its own enable but shares the window length
  lead_edge_blanker #(
    .CW(BLK_PERIOD_W)
  ) u_fault_blank (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_enable(blk_reg[BLK_FLT_EN_BIT]),
    .i_period(blk_reg[BLK_PERIOD_LSB +: BLK_PERIOD_W]),
    .i_edge  (blank_edge),
    .i_active(fault_act),
    .o_active(fault_blanked)
  );

  // latched fault holds until the source is idle and software clears the flag
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      latch_reg <= 1'b0;
    end else if (flc_reg[FLC_MODE_LSB +: 2] != MODE_LATCHED) begin
      latch_reg <= 1'b0;
    end else if (fault_blanked) begin
      latch_reg <= 1'b1;
    end else if (!status_reg[IRQ_FAULT_BIT]) begin
      latch_reg <= 1'b0;
    end
  end

  // cycle mode releases only at a period start so a pulse is never clipped mid-cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cycle_reg <= 1'b0;
    end else if (flc_reg[FLC_MODE_LSB +: 2] != MODE_CYCLE) begin
      cycle_reg <= 1'b0;
    end else if (fault_blanked) begin
      cycle_reg <= 1'b1;
    end else if (i_period_start) begin
      cycle_reg <= 1'b0;
    end
  end

  // mode 11 and reserved mode 10 never force; the flops above stay clear
  assign forcing = latch_reg | cycle_reg;

  // output stage, one flop after the mux
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      high_reg   <= 1'b0;
      low_reg    <= 1'b0;
      cl_out_reg <= 1'b0;
    end else begin
      high_reg   <= forcing ? i_fault_output_values[1] : i_pwm_high;
      low_reg    <= forcing ? i_fault_output_values[0] : i_pwm_low;
      cl_out_reg <= cl_blanked;
    end
  end

  // trigger compare, a zero value is never armed
  assign cmp_full   = {trg_reg[TRG_CMP_LSB +: TRG_CMP_W], 3'b000};
  assign cmp_hit    = (i_time_base == cmp_full)
                    && (trg_reg[TRG_CMP_LSB +: TRG_CMP_W] != '0);
  assign trig_event = cmp_hit & ~cmp_hit_prev_reg;

  // one pulse per match even if the time base pauses on the value
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_hit_prev_reg <= 1'b0;
      trig_reg         <= 1'b0;
    end else begin
      cmp_hit_prev_reg <= cmp_hit;
      trig_reg         <= trig_event;
    end
  end

  // rising edges of the conditions that raise status flags
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fault_prev_reg <= 1'b0;
      cl_prev_reg    <= 1'b0;
    end else begin
      fault_prev_reg <= fault_blanked & (flc_reg[FLC_MODE_LSB +: 2] != MODE_DISABLED);
      cl_prev_reg    <= cl_blanked;
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_reg <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (wr && i_paddr == OFS_INT_STATUS && i_pwdata[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
      if (fault_blanked && flc_reg[FLC_MODE_LSB +: 2] != MODE_DISABLED
          && !fault_prev_reg) begin
        status_reg[IRQ_FAULT_BIT] <= 1'b1;
      end
      if (trig_event) begin
        status_reg[IRQ_TRIGGER_BIT] <= 1'b1;
      end
      if (cl_blanked && !cl_prev_reg) begin
        status_reg[IRQ_CLIMIT_BIT] <= 1'b1;
      end
    end
  end

  // level interrupt from the unmasked flags
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  assign o_prdata           = prdata_reg;
  assign o_pready           = pready_reg;
  assign o_pslverr          = pslverr_reg;
  assign o_high_side_output = high_reg;
  assign o_low_side_output  = low_reg;
  assign o_current_limit    = cl_out_reg;
  assign o_adc_trigger      = trig_reg;
  assign o_irq              = irq_reg;
endmodule : pwm_fault_and_adc_trigger
`default_nettype wire

//--- tb/pwm_fault_checker_sva.sv
// assertion checker for the pwm fault and adc trigger block
`default_nettype none
module pwm_fault_checker
  import pwm_fault_pkg::*;
#(
  parameter int TB_W = 16
) (
  // clock and reset
  input wire logic            i_clk,
  input wire logic            i_nrst,
  // apb
  input wire logic            i_psel,
  input wire logic            i_penable,
  input wire logic            i_pwrite,
  input wire logic [7:0]      i_paddr,
  input wire logic [31:0]     i_pwdata,
  input wire logic [31:0]     o_prdata,
  input wire logic            o_pready,
  input wire logic            o_pslverr,
  // generator side
  input wire logic [3:0]      i_comparator,
  input wire logic [TB_W-1:0] i_time_base,
  input wire logic            i_pwm_high,
  input wire logic            i_pwm_low,
  input wire logic [1:0]      i_fault_output_values,
  input wire logic            o_high_side_output,
  input wire logic            o_low_side_output,
  input wire logic            o_adc_trigger
);
  logic [15:0] flc_q;
  logic [12:0] cmp_q;

  // shadow copies, taken at the edge where a write completes
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flc_q <= 16'h0000;
      cmp_q <= 13'h0000;
    end else if (i_psel && i_penable && o_pready && i_pwrite) begin
      if (i_paddr == OFS_FAULT_LIMIT_CONTROL) flc_q <= i_pwdata[15:0];
      if (i_paddr == OFS_ADC_TRIGGER_COMPARE) cmp_q <= i_pwdata[15:3];
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_pready_wait: assert property (i_psel && !i_penable |=> !o_pready ##1 o_pready)
    else $error("pready not in second access cycle");
  a_err_addr: assert property (o_pready |-> o_pslverr == (i_paddr > 8'h14 || i_paddr[1:0] != 2'h0))
    else $error("slave error does not match address");
  a_flc_upper: assert property (o_pready && !i_pwrite && i_paddr == 8'h00 |-> o_prdata[31:13] == 19'h0)
    else $error("control upper bits not zero");
  a_trig_low: assert property (o_pready && !i_pwrite && i_paddr == 8'h04 |-> o_prdata[2:0] == 3'h0)
    else $error("compare low bits not zero");
  a_trig_pulse: assert property (o_adc_trigger |=> !o_adc_trigger)
    else $error("trigger longer than one cycle");
  a_trig_match: assert property (o_adc_trigger |-> $past(cmp_q) != 13'h0 && $past(i_time_base) == {$past(cmp_q), 3'h0})
    else $error("trigger without time base match");
  a_mode_off: assert property (flc_q[1:0] == 2'h3 && $past(flc_q[1:0]) == 2'h3 && $past(flc_q[1:0], 2) == 2'h3
    |-> o_high_side_output == $past(i_pwm_high) && o_low_side_output == $past(i_pwm_low))
    else $error("outputs forced while fault disabled");
  a_force_rise: assert property ($rose(i_comparator[0]) && flc_q[6:0] == 7'h01 |-> ##[3:5]
    (o_high_side_output == i_fault_output_values[1] && o_low_side_output == i_fault_output_values[0]))
    else $error("comparator fault did not force outputs");
  a_force_fall: assert property ($fell(i_comparator[0]) && flc_q[6:0] == 7'h05 |-> ##[3:5]
    (o_high_side_output == i_fault_output_values[1] && o_low_side_output == i_fault_output_values[0]))
    else $error("active low fault did not force outputs");
endmodule : pwm_fault_checker

bind pwm_fault_and_adc_trigger pwm_fault_checker #(.TB_W(TB_W)) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_comparator(i_comparator),
  .i_time_base(i_time_base), .i_pwm_high(i_pwm_high), .i_pwm_low(i_pwm_low),
  .i_fault_output_values(i_fault_output_values), .o_high_side_output(o_high_side_output),
  .o_low_side_output(o_low_side_output), .o_adc_trigger(o_adc_trigger));
`default_nettype wire

//--- tb/pwm_far_side.sv
// far side model: time base, generator outputs, fault pins and adc trigger counter
`default_nettype none
module pwm_far_side #(
  parameter int PER = 32
) (
  // clock and reset
  input wire logic   i_clk,
  input wire logic   i_nrst,
  // bench commands and block trigger
  input wire logic [9:0] i_fault,
  input wire logic   i_adc_trigger,
  // generator
  output logic [15:0] o_time_base,
  output logic        o_period_start,
  output logic        o_pwm_high,
  output logic        o_pwm_low,
  // fault pins and trigger count
  output logic [3:0]  o_comparator,
  output logic [3:0]  o_shared_fault,
  output logic        o_indep_two,
  output logic        o_indep_four,
  output logic [7:0]  o_trig_count
);
  // time base restarts every period so each compare value recurs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) o_time_base <= 16'h0000;
    else if (o_time_base == 16'(PER - 1)) o_time_base <= 16'h0000;
    else o_time_base <= o_time_base + 16'h0001;
  end
  assign o_period_start = (o_time_base == 16'h0000);
  assign o_pwm_high = (o_time_base < 16'(PER / 2));
  assign o_pwm_low = !o_pwm_high;

  // pins lag the command by a clock, as an outside driver would
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) {o_indep_four, o_indep_two, o_shared_fault, o_comparator} <= 10'h000;
    else {o_indep_four, o_indep_two, o_shared_fault, o_comparator} <= i_fault;
  end

  // the converter side only counts trigger pulses
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) o_trig_count <= 8'h00;
    else if (i_adc_trigger) o_trig_count <= o_trig_count + 8'h01;
  end
endmodule : pwm_far_side
`default_nettype wire

//--- tb/test_pwm_fault_and_adc_trigger.sv
// self-checking bench for the pwm fault and adc trigger block
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module test_pwm_fault_and_adc_trigger
  import pwm_fault_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk, i_nrst, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, er, hi, lo, irq, trg, pst, ph, pl, if2, if4, clim;
  logic [1:0]  fdat;
  logic [15:0] tbase;
  logic [3:0]  cmp, shf;
  logic [9:0]  fault;
  logic [7:0]  tcnt, t0;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cyc = 0;

  pwm_fault_and_adc_trigger #(.TB_W(16)) DUT (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_comparator(cmp), .i_shared_fault(shf),
    .i_independent_fault_two(if2), .i_independent_fault_four(if4), .i_time_base(tbase),
    .i_period_start(pst), .i_pwm_high(ph), .i_pwm_low(pl), .i_fault_output_values(fdat),
    .o_high_side_output(hi), .o_low_side_output(lo), .o_current_limit(clim),
    .o_adc_trigger(trg), .o_irq(irq));
  pwm_far_side #(.PER(32)) u_far (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_fault(fault), .i_adc_trigger(trg),
    .o_time_base(tbase), .o_period_start(pst), .o_pwm_high(ph), .o_pwm_low(pl),
    .o_comparator(cmp), .o_shared_fault(shf), .o_indep_two(if2), .o_indep_four(if4),
    .o_trig_count(tcnt));

  // clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic end_sim;
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // one apb transfer; the request is held until pready is seen at a rising edge,
  // and read data is taken at that same edge; only the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : xfer

  // which fault line a source code should pick: 0-3 cmp, 4-7 shared, 8, 9 independent
  function automatic logic routed(input logic [3:0] c, input int p);
    if (c < 4'h4) return p == int'(c);
    if (c >= 4'h8 && c <= 4'hb) return p == int'(c) - 4;
    return (c == 4'hd && p == 8) || (c == 4'hf && p == 9);
  endfunction : routed

  task automatic t_regs;
    for (int a = 0; a <= 16; a += 4) begin
      xfer(1'b0, 8'(a), 32'h0);
      `CHK(rd, 32'h0)
    end
    xfer(1'b1, OFS_FAULT_LIMIT_CONTROL, 32'hffff_ffff);
    xfer(1'b0, OFS_FAULT_LIMIT_CONTROL, 32'h0);
    `CHK(rd, 32'h0000_1fff)
    xfer(1'b1, OFS_ADC_TRIGGER_COMPARE, 32'hffff_ffff);
    xfer(1'b0, OFS_ADC_TRIGGER_COMPARE, 32'h0);
    `CHK(rd, 32'h0000_fff8)
    xfer(1'b1, OFS_ADC_TRIGGER_COMPARE, 32'h0);
    xfer(1'b0, 8'h18, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
  endtask : t_regs

  // every code against every line, cycle mode so each release is checked too
  task automatic t_src;
    for (int c = 0; c < 16; c++) begin
      xfer(1'b1, OFS_FAULT_LIMIT_CONTROL, (32'(c) << 3) | 32'h1);
      for (int p = 0; p < 10; p++) begin
        @(posedge i_clk);
        fault <= 10'h001 << p;
        repeat (8) @(negedge i_clk);
        `CHK(hi & lo, routed(4'(c), p))
        @(posedge i_clk);
        fault <= 10'h000;
        repeat (48) @(negedge i_clk);
        `CHK(hi & lo, 1'b0)
      end
    end
  endtask : t_src

  task automatic t_pol;
    xfer(1'b1, OFS_FAULT_LIMIT_CONTROL, 32'h5);
    repeat (8) @(negedge i_clk);
    `CHK(hi & lo, 1'b1)
    @(posedge i_clk);
    fault <= 10'h001;
    repeat (48) @(negedge i_clk);
    `CHK(hi & lo, 1'b0)
    @(posedge i_clk);
    fault <= 10'h000;
    repeat (8) @(negedge i_clk);
    `CHK(hi & lo, 1'b1)
    // unequal fault values catch a swap of the high and low side
    @(posedge i_clk);
    fdat <= 2'h2;
    repeat (2) @(negedge i_clk);
    `CHK({hi, lo}, 2'b10)
    @(posedge i_clk);
    fdat <= 2'h3;
  endtask : t_pol

  // latched fault outlives period starts until software clears it
  task automatic t_latch;
    xfer(1'b1, OFS_FAULT_LIMIT_CONTROL, 32'h0);
    xfer(1'b1, OFS_INT_STATUS, 32'h7);
    xfer(1'b1, OFS_INT_MASK, 32'h0);
    @(posedge i_clk);
    fault <= 10'h001;
    repeat (8) @(posedge i_clk);
    fault <= 10'h000;
    repeat (48) @(negedge i_clk);
    `CHK({hi & lo, irq}, 2'b10)
    xfer(1'b0, OFS_INT_STATUS, 32'h0);
    `CHK(rd[0], 1'b1)
    xfer(1'b1, OFS_INT_MASK, 32'h1);
    repeat (2) @(negedge i_clk);
    `CHK(irq, 1'b1)
    xfer(1'b1, OFS_INT_STATUS, 32'h1);
    repeat (4) @(negedge i_clk);
    `CHK({hi & lo, irq}, 2'b00)
    xfer(1'b1, OFS_FAULT_LIMIT_CONTROL, 32'h3);
    @(posedge i_clk);
    fault <= 10'h001;
    repeat (8) @(negedge i_clk);
    `CHK(hi & lo, 1'b0)
    @(posedge i_clk);
    fault <= 10'h000;
  endtask : t_latch

  task automatic t_trig;
    xfer(1'b1, OFS_INT_STATUS, 32'h7);
    xfer(1'b1, OFS_INT_MASK, 32'h2);
    xfer(1'b1, OFS_ADC_TRIGGER_COMPARE, 32'h8);
    t0 = tcnt;
    // 66 edges hold two matches, or three if the first one falls within the first two edges
    repeat (66) @(negedge i_clk);
    `CHK({tcnt - t0, irq}, 9'h005)
    xfer(1'b1, OFS_ADC_TRIGGER_COMPARE, 32'h0);
    xfer(1'b1, OFS_INT_STATUS, 32'h2);
    t0 = tcnt;
    repeat (64) @(negedge i_clk);
    `CHK({tcnt - t0, irq}, 9'h000)
  endtask : t_trig

  // current-limit pin held active; blanking hides it for fifteen clocks after each high rise
  task automatic t_clim;
    logic [7:0] n;
    xfer(1'b1, OFS_FAULT_LIMIT_CONTROL, 32'h83);
    @(posedge i_clk);
    fault <= 10'h001;
    for (int e = 1; e >= 0; e--) begin
      xfer(1'b1, OFS_BLANKING_CONTROL, (e == 1) ? 32'h8478 : 32'h8078);
      repeat (40) @(negedge i_clk);
      n = 8'h00;
      repeat (64) begin
        @(negedge i_clk);
        n = n + {7'h00, clim};
      end
      `CHK(n, (e == 1) ? 8'h22 : 8'h40)
    end
    @(posedge i_clk);
    fault <= 10'h000;
  endtask : t_clim

  // the full run needs about 10000 cycles; a hang is cut off well beyond that
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      end_sim();
    end
  end

  // reset, then the scenarios in order
  initial begin
    i_nrst = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    fault = 10'h000;
    fdat = 2'h3;
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_regs();
    t_src();
    t_pol();
    t_latch();
    t_trig();
    t_clim();
    end_sim();
  end
endmodule : test_pwm_fault_and_adc_trigger
`default_nettype wire
